// file: rtl/usb_bridge_irq_status.sv
// Purpose: Interrupt status collector of the USB core bus bridge, reached
//          over AHB-Lite, with a power detect control and DMA setting word.
// Assumes: Events are one-cycle pulses on hclk; core levels are on hclk;
//          only the power input pin is asynchronous.
// Notes:   Zero-wait slave, every answer OKAY.
//
// Overview of operation
// - Master write start on common bus flags error
// - Power input level change, once stable over two synchroniser samples, sets flag
// - Indirect bridge read completion sets flag
// - Core read or write completion sets flag
// - Bus error during master read sets flag
// - Transmit FIFO becoming writable sets flag
// - Master read finish sets flag
// - Bus error during master write sets flag
// - Timeout during master write sets flag
// - Master write finish sets flag
// - Write data while write disabled requests address
// - Bus-reset release and assert set flags
// - Reset-release flag marks core reload moment
// - Bus-reset flags sticky, not live level
// - Live bus-reset level readable in power register
// - Suspend change sets flag, level readable
// - Low bits mirror core flags directly
`timescale 1ns/10ps
`default_nettype none

`include "usb_irq_defines.svh"

module usb_bridge_irq_status (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bridge events and levels
  input wire usb_irq_pkg::bridge_events_t events,
  input wire usb_irq_pkg::bridge_levels_t levels,
  input wire logic [7:0] core_flags,
  // Power input pin
  input wire logic vbus_power_input,
  // Engine reset controls
  output logic mrd_engine_reset,
  output logic mwr_engine_reset
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [31:0] STICKY = `STS_STICKY_MASK; // Bridge-owned bits
  logic [31:0] flag_q;       // Sticky flag bits
  logic [31:0] flag_d;       // Next value of the flags
  logic [31:0] event_vec;    // Set terms, one per bit
  logic [31:0] clr_vec;      // Write-one-to-clear terms
  logic [31:0] rd_value;     // Read mux result
  logic addr_ok;             // Address phase accepted
  logic wr_pend_q;           // Write data phase pending
  logic [`ADDR_DECODE_W-1:0] wr_addr_q; // Address of pending write
  logic [1:0] dma_q;         // DMA setting word
  logic [1:0] dma_d;         // Next DMA setting word
  logic fifo_nf_q;           // Previous FIFO writable level
  logic usb_reset_q;         // Previous bus-reset level
  logic suspend_q;           // Previous suspend level
  logic vbus_level;          // Filtered power input level
  logic vbus_change;         // One-cycle power change pulse
  logic [`ADDR_DECODE_W-1:0] addr_lo; // Decoded part of haddr

  assign addr_lo = haddr[`ADDR_DECODE_W-1:0];
  assign addr_ok = hsel && hready && htrans[1];

  // ----------------------------------------------------------------------
  // Power input synchroniser
  // ----------------------------------------------------------------------
  vbus_change_sync u_vbus (
    .hclk(hclk),
    .hresetn(hresetn),
    .vbus_power_input(vbus_power_input),
    .level_q(vbus_level),
    .change_q(vbus_change)
  );

  // ----------------------------------------------------------------------
  // Level history for edge detection
  // ----------------------------------------------------------------------
  // Core levels share hclk, so they need no synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_nf_q <= 1'b0;
      usb_reset_q <= 1'b0;
      suspend_q <= 1'b0;
    end else begin
      fifo_nf_q <= levels.mrd_fifo_not_full;
      usb_reset_q <= levels.usb_reset;
      suspend_q <= levels.suspend;
    end
  end

  // ----------------------------------------------------------------------
  // Event terms
  // ----------------------------------------------------------------------
  always_comb begin
    event_vec = 32'h0000_0000;
    // Only common bus access counts as a read error
    event_vec[`BIT_MWR_RERR] = events.mwr_xfer_start && !levels.ep_bus_sel;
    event_vec[`BIT_PWR_DETECT] = vbus_change;
    event_vec[`BIT_DMAC_RD] = events.dmac_rd_done;
    event_vec[`BIT_CORE_DONE] = events.core_rd_done || events.core_wr_done;
    // Errors outside a running transfer are ignored
    event_vec[`BIT_MRD_BERR] = events.mrd_ahb_error && levels.mrd_active;
    // Rising edge only: a FIFO that stays writable flags once
    event_vec[`BIT_MRD_FIFO_WR] = levels.mrd_fifo_not_full && !fifo_nf_q;
    event_vec[`BIT_MRD_DONE] = events.mrd_done;
    event_vec[`BIT_MWR_BERR] = events.mwr_ahb_error && levels.mwr_active;
    event_vec[`BIT_MWR_TOUT] = events.mwr_timeout && levels.mwr_active;
    event_vec[`BIT_MWR_DONE] = events.mwr_done;
    event_vec[`BIT_MWR_ADDR_REQ] = events.mwr_rx_data && !levels.mwr_enable;
    // Falling edge of bus reset is the core reload moment
    event_vec[`BIT_RESET_END] = usb_reset_q && !levels.usb_reset;
    event_vec[`BIT_RESET_START] = levels.usb_reset && !usb_reset_q;
    event_vec[`BIT_SUSPEND_CHG] = levels.suspend != suspend_q;
  end

  // ----------------------------------------------------------------------
  // Clear terms from the write data phase
  // ----------------------------------------------------------------------
  always_comb begin
    clr_vec = 32'h0000_0000;
    if (wr_pend_q && wr_addr_q == `REG_INT_STATUS) begin
      clr_vec = hwdata & STICKY;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags, one per bridge-owned bit
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
      if (STICKY[gi]) begin : g_sticky
        // Set wins over a clear in the same cycle
        assign flag_d[gi] = event_vec[gi] || (flag_q[gi] && !clr_vec[gi]);
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            flag_q[gi] <= 1'b0;
          end else begin
            flag_q[gi] <= flag_d[gi];
          end
        end
      end else begin : g_none
        // Mirrored or reserved bits hold no state here
        assign flag_d[gi] = 1'b0;
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------------
  // Only whole-word transfers are expected; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= `REG_INT_STATUS;
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= addr_lo;
    end
  end

  // ----------------------------------------------------------------------
  // DMA setting word with the engine resets
  // ----------------------------------------------------------------------
  always_comb begin
    dma_d = dma_q;
    if (wr_pend_q && wr_addr_q == `REG_DMA_SETTING) begin
      dma_d[`DMA_BIT_MWR_RESET] = hwdata[`DMA_BIT_MWR_RESET];
      dma_d[`DMA_BIT_MRD_RESET] = hwdata[`DMA_BIT_MRD_RESET];
    end
  end

  // Software sets and releases each reset; no self-clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_q <= `RST_DMA_SETTING;
    end else begin
      dma_q <= dma_d;
    end
  end

  assign mwr_engine_reset = dma_q[`DMA_BIT_MWR_RESET];
  assign mrd_engine_reset = dma_q[`DMA_BIT_MRD_RESET];

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Status reads use flag_d so a clear just written is already visible
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (addr_lo)
      `REG_INT_STATUS: begin
        rd_value = flag_d;
        rd_value[`CORE_FLAG_W-1:0] = core_flags;
      end
      `REG_DMA_SETTING: begin
        rd_value[1:0] = dma_d;
      end
      `REG_POWER_DETECT: begin
        rd_value[`PWR_BIT_VBUS] = vbus_level;
        rd_value[`PWR_BIT_USB_RESET] = levels.usb_reset;
        rd_value[`PWR_BIT_SUSPEND] = levels.suspend;
      end
      default: begin
        // Unmapped words read as zero
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RST_RDATA;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_MWR_RERR: assert property (events.mwr_xfer_start && !levels.ep_bus_sel |=> flag_q[29])
    else $error("write read error flag not set");
  AST_VBUS: assert property ($changed(vbus_level) |=> flag_q[28])
    else $error("power detect flag not set");
  AST_DMAC_RD: assert property (events.dmac_rd_done |=> flag_q[25])
    else $error("bridge read flag not set");
  AST_CORE_DONE: assert property (events.core_rd_done || events.core_wr_done |=> flag_q[24])
    else $error("core access flag not set");
  AST_MRD_BERR: assert property (events.mrd_ahb_error && levels.mrd_active |=> flag_q[23])
    else $error("read bus error flag not set");
  AST_FIFO_WR: assert property ($rose(levels.mrd_fifo_not_full) |=> flag_q[22])
    else $error("fifo writable flag not set");
  AST_MRD_DONE: assert property (events.mrd_done |=> flag_q[21])
    else $error("read done flag not set");
  AST_MWR_BERR: assert property (events.mwr_ahb_error && levels.mwr_active |=> flag_q[20])
    else $error("write bus error flag not set");
  AST_MWR_TOUT: assert property (events.mwr_timeout && levels.mwr_active |=> flag_q[19])
    else $error("write timeout flag not set");
  AST_MWR_DONE: assert property (events.mwr_done |=> flag_q[18])
    else $error("write done flag not set");
  AST_ADDR_REQ: assert property (events.mwr_rx_data && !levels.mwr_enable |=> flag_q[17])
    else $error("address request flag not set");
  AST_RESET_EDGES: assert property ($fell(levels.usb_reset) |=> flag_q[10] && !$rose(flag_q[9]))
    else $error("reset end flag not set");
  AST_RESET_START: assert property ($rose(levels.usb_reset) |=> flag_q[9])
    else $error("reset start flag not set");
  AST_SUSPEND: assert property ($changed(levels.suspend) |=> flag_q[8])
    else $error("suspend change flag not set");
  AST_STICKY: assert property (1'b1 |=> (($past(flag_q) & ~$past(clr_vec) & ~flag_q) == 32'h0000_0000))
    else $error("sticky flag dropped without clear");
  AST_NO_SPURIOUS: assert property (1'b1 |=> ((flag_q & ~$past(flag_q) & ~$past(event_vec)) == 32'h0000_0000))
    else $error("flag set without event");
  AST_PWR_READ: assert property (addr_ok && !hwrite && addr_lo == `REG_POWER_DETECT |=> hrdata[1] == $past(levels.usb_reset) && hrdata[31:3] == 29'h0)
    else $error("power register read wrong");
  AST_CORE_MIRROR: assert property (addr_ok && !hwrite && addr_lo == `REG_INT_STATUS |=> hrdata[7:0] == $past(core_flags))
    else $error("core flags not mirrored");

  COV_VBUS: cover property (vbus_change ##[1:20] wr_pend_q && clr_vec[28]);
  COV_RESET_END: cover property ($rose(levels.usb_reset) ##[1:50] $fell(levels.usb_reset));
  COV_SET_CLEAR: cover property (|(event_vec & clr_vec));
  COV_WR_RD: cover property (wr_pend_q ##0 addr_ok && !hwrite);

endmodule : usb_bridge_irq_status

`default_nettype wire

// file: rtl/vbus_change_sync.sv
// Purpose: Brings the power input pin into hclk and flags level changes.
// Assumes: Pin is asynchronous to hclk.
// Notes:   A change counts only once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none

module vbus_change_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin side
  input wire logic vbus_power_input,
  // Filtered level and change pulse
  output logic level_q,
  output logic change_q
);

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  logic s1_q; // First stage, read only by s2_q
  logic s2_q; // Second stage
  logic s3_q; // Third stage, agreement check

  // Three flip-flops on the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= vbus_power_input;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Accepted level and change pulse
  // ----------------------------------------------------------------------
  // Level starts low, so a supply present at reset gives one change event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'b0;
      change_q <= 1'b0;
    end else begin
      change_q <= 1'b0;
      if (s2_q == s3_q && s3_q != level_q) begin
        // Either direction counts as a change
        level_q <= s3_q;
        change_q <= 1'b1;
      end
    end
  end

endmodule : vbus_change_sync

`default_nettype wire

// file: shared/usb_irq_defines.svh
// Purpose: Offsets, field positions and reset values of the
//          bridge interrupt status block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes:   Definitions only, no logic.
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_INT_STATUS 12'h000
`define REG_DMA_SETTING 12'h010
`define REG_POWER_DETECT 12'h080
`define ADDR_DECODE_W 12

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define BIT_MWR_RERR 29
`define BIT_PWR_DETECT 28
`define BIT_DMAC_RD 25
`define BIT_CORE_DONE 24
`define BIT_MRD_BERR 23
`define BIT_MRD_FIFO_WR 22
`define BIT_MRD_DONE 21
`define BIT_MWR_BERR 20
`define BIT_MWR_TOUT 19
`define BIT_MWR_DONE 18
`define BIT_MWR_ADDR_REQ 17
`define BIT_RESET_END 10
`define BIT_RESET_START 9
`define BIT_SUSPEND_CHG 8
`define CORE_FLAG_W 8

// Bits owned by the bridge and kept sticky
`define STS_STICKY_MASK 32'h33FE_0700

// ----------------------------------------------------------------------
// Power detect control and DMA setting fields
// ----------------------------------------------------------------------
`define PWR_BIT_VBUS 0
`define PWR_BIT_USB_RESET 1
`define PWR_BIT_SUSPEND 2
`define DMA_BIT_MWR_RESET 0
`define DMA_BIT_MRD_RESET 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INT_STATUS 32'h0000_0000
`define RST_DMA_SETTING 2'h0
`define RST_RDATA 32'h0000_0000

`endif

// file: shared/usb_irq_pkg.sv
// Purpose: Types shared by the bridge interrupt status block.
// Assumes: All event pulses are one cycle wide on hclk.
// Notes:   Constants live in usb_irq_defines.svh.
`default_nettype none

package usb_irq_pkg;

  // One-cycle event pulses from the bridge engines
  typedef struct packed {
    logic mwr_xfer_start;   // Endpoint access started a master write
    logic dmac_rd_done;     // Indirect read value captured
    logic core_rd_done;     // Core register read value captured
    logic core_wr_done;     // Core register write finished
    logic mrd_ahb_error;    // Error response on the master read path
    logic mrd_done;         // Master read transfer finished
    logic mwr_ahb_error;    // Error response on the master write path
    logic mwr_timeout;      // Master write timeout expired
    logic mwr_done;         // Master write transfer finished
    logic mwr_rx_data;      // Receive endpoint got master write data
  } bridge_events_t;

  // Levels from the bridge engines and the device core
  typedef struct packed {
    logic ep_bus_sel;       // 0 = common bus access for the endpoint
    logic mrd_active;       // Master read transfer running
    logic mwr_active;       // Master write transfer running
    logic mwr_enable;       // Master write transfer enabled
    logic mrd_fifo_not_full; // Transmit endpoint FIFO writable
    logic usb_reset;        // Core bus-reset signal
    logic suspend;          // Core suspend state signal
  } bridge_levels_t;

endpackage : usb_irq_pkg

`default_nettype wire

// file: tb/test_usb_bridge_irq_status.sv
// Purpose: Self-checking bench of the bridge interrupt status block.
// Assumes: Zero-wait AHB-Lite slave; the bench is the only master.
// Notes:   Each scenario task drives and judges on its own.
`timescale 1ns/10ps
`default_nettype none

`include "usb_irq_defines.svh"

module test_usb_bridge_irq_status;
  // ------------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic mrd_rst;
  logic mwr_rst;
  usb_irq_pkg::bridge_events_t events;
  usb_irq_pkg::bridge_levels_t levels;
  logic [7:0] core_flags;
  logic vbus;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [31:0] A_STS = 32'(`REG_INT_STATUS);
  localparam logic [31:0] A_DMA = 32'(`REG_DMA_SETTING);
  localparam logic [31:0] A_PWR = 32'(`REG_POWER_DETECT);
  localparam logic [31:0] CLR = `STS_STICKY_MASK;

  // 10 MHz clock
  always #50 hclk = ~hclk;

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  usb_core_model i_core (.hclk(hclk), .events(events), .levels(levels),
    .core_flags(core_flags), .vbus_power_input(vbus));

  usb_bridge_irq_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .events(events), .levels(levels), .core_flags(core_flags),
    .vbus_power_input(vbus), .mrd_engine_reset(mrd_rst), .mwr_engine_reset(mwr_rst));

  // ------------------------------------------------------------------
  // Bus master and comparison
  // ------------------------------------------------------------------
  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rd_chk

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Reset values, OKAY answer, unmapped and read-only places
  task automatic t_reset();
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    rd_chk(A_STS, 32'h0000_0000);
    rd_chk(A_DMA, 32'h0000_0000);
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rd_chk(32'h0000_0100, 32'h0000_0000);
    wr(A_PWR, 32'hFFFF_FFFF);
    rd_chk(A_PWR, 32'h0000_0000);
  endtask : t_reset

  // Every engine event, with its qualifier met and then missing
  task automatic t_events();
    int evx[15] = '{9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 9, 5, 3, 2, 0};
    logic [6:0] lvt[15] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h20, 7'h00, 7'h10, 7'h10,
                             7'h00, 7'h00, 7'h40, 7'h00, 7'h00, 7'h00, 7'h08};
    int bit_of[15] = '{29, 25, 24, 24, 23, 21, 20, 19, 18, 17, -1, -1, -1, -1, -1};
    logic [31:0] e;
    for (int i = 0; i < 15; i++) begin
      e = (bit_of[i] < 0) ? 32'h0000_0000 : 32'h0000_0001 << bit_of[i];
      i_core.set_lv(lvt[i]);
      i_core.pulse(usb_irq_pkg::bridge_events_t'(10'h001 << evx[i]));
      rd_chk(A_STS, e);
      rd_chk(A_STS, e);
      wr(A_STS, CLR);
      rd_chk(A_STS, 32'h0000_0000);
    end
    i_core.set_lv(7'h00);
  endtask : t_events

  // Bus-reset, suspend and FIFO level edges; flags stay sticky
  task automatic t_levels();
    logic [6:0] lv[7] = '{7'h02, 7'h02, 7'h00, 7'h01, 7'h00, 7'h04, 7'h00};
    logic [31:0] es[7] = '{32'h0000_0200, 32'h0000_0000, 32'h0000_0400, 32'h0000_0100,
                           32'h0000_0100, 32'h0040_0000, 32'h0000_0000};
    logic [31:0] ep[7] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0000, 32'h0000_0004,
                           32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 7; i++) begin
      i_core.set_lv(lv[i]);
      rd_chk(A_STS, es[i]);
      rd_chk(A_PWR, ep[i]);
      wr(A_STS, CLR);
    end
  endtask : t_levels

  // Power pin changes both ways
  task automatic t_vbus();
    for (int v = 1; v >= 0; v--) begin
      i_core.set_vbus(v[0]);
      repeat (8) @(posedge hclk);
      rd_chk(A_STS, 32'h1000_0000);
      rd_chk(A_PWR, 32'(v));
      wr(A_STS, CLR);
      rd_chk(A_STS, 32'h0000_0000);
    end
  endtask : t_vbus

  // Core flags mirror; a status write cannot clear them
  task automatic t_flags();
    i_core.set_flags(8'hA5);
    rd_chk(A_STS, 32'h0000_00A5);
    wr(A_STS, 32'hFFFF_FFFF);
    rd_chk(A_STS, 32'h0000_00A5);
    i_core.set_flags(8'h00);
    rd_chk(A_STS, 32'h0000_0000);
  endtask : t_flags

  // Software sets both engine resets, then releases them one at a time
  task automatic t_dma();
    wr(A_DMA, 32'h0000_0003);
    // The reset bits settle after the data-phase edge, so look mid-cycle
    @(negedge hclk);
    chk({30'h0, mrd_rst, mwr_rst}, 32'h0000_0003);
    rd_chk(A_DMA, 32'h0000_0003);
    wr(A_DMA, 32'h0000_0002);
    @(negedge hclk);
    chk({30'h0, mrd_rst, mwr_rst}, 32'h0000_0002);
    wr(A_DMA, 32'h0000_0000);
    rd_chk(A_DMA, 32'h0000_0000);
  endtask : t_dma

  // Reset in mid-run drops every flag and both engine resets
  task automatic t_mid_reset();
    i_core.pulse(usb_irq_pkg::bridge_events_t'(10'h010));
    wr(A_DMA, 32'h0000_0003);
    rd_chk(A_STS, 32'h0020_0000);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({30'h0, mrd_rst, mwr_rst}, 32'h0000_0000);
    rd_chk(A_STS, 32'h0000_0000);
    rd_chk(A_DMA, 32'h0000_0000);
  endtask : t_mid_reset

  // ------------------------------------------------------------------
  // Verdict and main sequence
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_events();
    t_levels();
    t_vbus();
    t_flags();
    t_dma();
    t_mid_reset();
    final_report();
  end
endmodule : test_usb_bridge_irq_status

`default_nettype wire

// file: tb/usb_core_model.sv
// Purpose: Far-side stand-in for the device core and the transfer engines.
// Assumes: All but the power pin are synchronous to hclk.
// Notes:   Drives only by NBA just after a rising edge, apart from the idle values at time zero.
`timescale 1ns/10ps
`default_nettype none

module usb_core_model (
  // Clock
  input wire logic hclk,
  // Toward the bridge
  output var usb_irq_pkg::bridge_events_t events,
  output var usb_irq_pkg::bridge_levels_t levels,
  output logic [7:0] core_flags,
  output logic vbus_power_input
);
  // ------------------------------------------------------------------
  // Idle state at time zero
  // ------------------------------------------------------------------
  initial begin
    events = '0;
    levels = '0;
    core_flags = 8'h00;
    vbus_power_input = 1'b0;
  end

  // ------------------------------------------------------------------
  // Stimulus tasks
  // ------------------------------------------------------------------
  // Engines pulse for exactly one cycle, never longer
  task automatic pulse(input usb_irq_pkg::bridge_events_t e);
    @(posedge hclk);
    events <= e;
    @(posedge hclk);
    events <= '0;
  endtask : pulse

  // Qualifying and core levels, held until the next call
  task automatic set_lv(input usb_irq_pkg::bridge_levels_t l);
    @(posedge hclk);
    levels <= l;
  endtask : set_lv

  // Core flag outputs; only the core itself clears them
  task automatic set_flags(input logic [7:0] f);
    @(posedge hclk);
    core_flags <= f;
  endtask : set_flags

  // Power pin, unrelated to hclk in the real system
  task automatic set_vbus(input logic v);
    @(posedge hclk);
    vbus_power_input <= v;
  endtask : set_vbus
endmodule : usb_core_model

`default_nettype wire
